// [design/dpr_host_pkg.sv]
// constants and carriers for the dual-port memory port controller
package dpr_host_pkg;

	// ---------------------------------------------------------------
	// widths and map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 36;
	localparam int LANE_W = 4;
	localparam int FLAG_AW = 3;
	localparam logic [ADDR_W-1:0] MBOX_RIGHT = 15'h7fff;
	localparam logic [ADDR_W-1:0] MBOX_LEFT = 15'h7ffe;
	localparam logic [ADDR_W-1:0] MBOX_RIGHT_16K = 15'h3fff;
	localparam logic [ADDR_W-1:0] MBOX_LEFT_16K = 15'h3ffe;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int SYNC_DEPTH = 3;
	localparam int T_ACCESS_NS = 15;
	localparam int T_FLOW_NS = 25;
	localparam int T_HOLD_SETTLE_NS = 15;
	localparam int T_FLAG_PULSE_NS = 10;
	localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int FLOW_CYC = (T_FLOW_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC = (T_HOLD_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int FLAG_PULSE_CYC = (T_FLAG_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] READ_WAIT = 4'(ACCESS_CYC + FLOW_CYC + SYNC_DEPTH);
	localparam logic [3:0] SETTLE_WAIT = 4'(SETTLE_CYC + SYNC_DEPTH);
	localparam logic [3:0] RECOVER_WAIT = 4'(FLAG_PULSE_CYC);

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [LANE_W-1:0] LANES_OFF = 4'hf;
	localparam logic [1:0] CTRL_IDLE = 2'h3;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;

	// ---------------------------------------------------------------
	// commands and carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_MEM_READ   = 2'b00,
		OP_MEM_WRITE  = 2'b01,
		OP_FLAG_READ  = 2'b10,
		OP_FLAG_WRITE = 2'b11
	} op_t;

	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANE_W-1:0] lanesN;
	} cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              portSelectLowTrue;
		logic              portSelectHighTrue;
		logic              flagLatchSelectN;
		logic [LANE_W-1:0] byteLaneSelectN;
		logic              outputEnableN;
		logic              writeReadN;
		logic [DATA_W-1:0] dataOut;
		logic              dataOe;
	} pins_t;

	localparam pins_t PINS_IDLE = '{
		addr: '0, portSelectLowTrue: 1'b1, portSelectHighTrue: 1'b0,
		flagLatchSelectN: 1'b1, byteLaneSelectN: LANES_OFF, outputEnableN: 1'b1,
		writeReadN: 1'b1, dataOut: '0, dataOe: 1'b0};

endpackage

// [design/pin_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int              W        = 1,
	parameter logic [W-1:0]    RESET_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pinIn,
	output var  logic [W-1:0] stable
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] stable_q;
	logic [W-1:0] stable_d;

	// ---------------------------------------------------------------
	// filter
	// ---------------------------------------------------------------
	// s1 feeds s2 only; per bit, a change counts once s2 and s3 agree
	always_comb begin
		stable_d = stable_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				stable_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q     <= RESET_VAL;
			s2_q     <= RESET_VAL;
			s3_q     <= RESET_VAL;
			stable_q <= RESET_VAL;
		end else begin
			s1_q     <= pinIn;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
		end
	end

	assign stable = stable_q;

endmodule // pin_sync
`default_nettype wire

// [design/dpr_port_host.sv]
// controller driving one port of the asynchronous dual-port memory
// Functional notes
// R1 - read/write control stays high during reads
// R2 - read/write control high while address changes
// R3 - write needs low control plus select
// R4 - device accepts either write termination order
// R5 - late select during low control floats outputs
// R6 - memory read: port select with output enable
// R7 - flag read: flag select with output enable
// R8 - every flag read is a fresh select cycle
// R9 - cross-port reads wait out flow delay
// R10 - top two words are the mailboxes
// R11 - writing other mailbox raises owner interrupt
// R12 - reading own mailbox clears own interrupt
// R13 - reading other mailbox clears nothing
// R14 - held port cannot set other interrupt
// R15 - held port cannot clear own interrupt
// R16 - arbiter grants one port, holds the other
// R17 - simultaneous flag requests: exactly one wins
// R18 - all flags start free
// R19 - role pin chooses hold output or input
// R20 - delay slave writes until hold settles
// R21 - eight flags, three low address bits
// R22 - claimed flag changeable only by owner
// R23 - partial lanes touch only selected bytes
// R24 - queued requester owns flag on release
// R25 - master inhibits held port's contended write
`timescale 1ns/10ps
`default_nettype none
module dpr_port_host
	import dpr_host_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic                      cmdValid,
	input  wire dpr_host_pkg::cmd_t        cmd,
	output var  logic                      cmdReady,
	output var  logic                      rspValid,
	output var  logic [dpr_host_pkg::DATA_W-1:0] rspData,
	output var  logic                      intPending,
	output var  logic                      holdSeen,
	output var  dpr_host_pkg::pins_t       pinsOut,
	input  wire logic [dpr_host_pkg::DATA_W-1:0] dataIn,
	input  wire logic                      holdN,
	input  wire logic                      mailIntN
);
	import dpr_host_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_SETTLE  = 3'b010,
		ST_RD_SEL  = 3'b011,
		ST_WR_SEL  = 3'b100,
		ST_WR_LOW  = 3'b101,
		ST_WR_END  = 3'b110,
		ST_RECOVER = 3'b111
	} state_t;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] dataSync;
	logic [1:0]        ctrlSync;

	pin_sync #(.W(DATA_W), .RESET_VAL(DATA_ZERO)) u_data_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pinIn   (dataIn),
		.stable  (dataSync)
	);

	pin_sync #(.W(2), .RESET_VAL(CTRL_IDLE)) u_ctrl_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pinIn   ({holdN, mailIntN}),
		.stable  (ctrlSync)
	);

	logic holdActive;
	logic intActive;
	assign holdActive = ~ctrlSync[1];
	assign intActive  = ~ctrlSync[0];

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	state_t            state_q;
	state_t            state_d;
	cmd_t              cmd_q;
	cmd_t              cmd_d;
	pins_t             pins_q;
	pins_t             pins_d;
	logic [3:0]        wait_q;
	logic [3:0]        wait_d;
	logic              ready_q;
	logic              ready_d;
	logic              rspValid_q;
	logic              rspValid_d;
	logic [DATA_W-1:0] rspData_q;
	logic [DATA_W-1:0] rspData_d;
	logic              intPending_q;
	logic              holdSeen_q;
	logic              isFlag;
	logic              isWrite;

	assign isFlag  = cmd_q.op[1];
	assign isWrite = cmd_q.op[0];

	always_comb begin
		state_d    = state_q;
		cmd_d      = cmd_q;
		pins_d     = pins_q;
		wait_d     = wait_q;
		ready_d    = 1'b0;
		rspValid_d = 1'b0;
		rspData_d  = rspData_q;
		case (state_q)
			ST_IDLE: begin
				ready_d = 1'b1;
				if (cmdValid && ready_q) begin
					cmd_d          = cmd;
					ready_d        = 1'b0;
					// address moves only with control high and selects off
					pins_d         = PINS_IDLE; // see R2
					pins_d.addr    = cmd.op[1] ? {12'h000, cmd.addr[FLAG_AW-1:0]} : cmd.addr; // see R21
					wait_d         = SETTLE_WAIT;
					state_d        = ST_ADDR;
				end
			end
			ST_ADDR: begin
				// hold must be settled and released before any write starts
				if (wait_q != 4'h0) begin
					wait_d = wait_q - 4'h1;
				end else if (isWrite && holdActive) begin
					state_d = ST_SETTLE; // see R20
				end else if (isWrite) begin
					pins_d.dataOe  = 1'b1;
					pins_d.dataOut = isFlag ? {35'h0, cmd_q.data[0]} : cmd_q.data;
					state_d        = ST_WR_SEL;
				end else begin
					pins_d.writeReadN    = 1'b1; // see R1
					pins_d.outputEnableN = 1'b0;
					if (isFlag) begin
						pins_d.flagLatchSelectN = 1'b0; // see R7
					end else begin
						pins_d.portSelectLowTrue  = 1'b0; // see R6
						pins_d.portSelectHighTrue = 1'b1;
						pins_d.byteLaneSelectN    = cmd_q.lanesN; // see R23
					end
					wait_d  = READ_WAIT; // see R9
					state_d = ST_RD_SEL;
				end
			end
			ST_SETTLE: begin
				// a held port waits; its write would land on a contended word
				if (!holdActive) begin
					wait_d  = SETTLE_WAIT; // see R25
					state_d = ST_ADDR;
				end
			end
			ST_RD_SEL: begin
				if (wait_q != 4'h0) begin
					wait_d = wait_q - 4'h1;
				end else begin
					rspData_d  = isFlag ? {35'h0, dataSync[0]} : dataSync;
					rspValid_d = 1'b1;
					pins_d     = PINS_IDLE;
					pins_d.addr = pins_q.addr;
					wait_d     = RECOVER_WAIT;
					state_d    = ST_RECOVER; // see R8
				end
			end
			ST_WR_SEL: begin
				// select first, then control low, so outputs never turn on
				if (isFlag) begin
					pins_d.flagLatchSelectN = 1'b0; // see R3
				end else begin
					pins_d.portSelectLowTrue  = 1'b0; // see R3
					pins_d.portSelectHighTrue = 1'b1;
					pins_d.byteLaneSelectN    = cmd_q.lanesN; // see R23
				end
				state_d = ST_WR_LOW;
			end
			ST_WR_LOW: begin
				pins_d.writeReadN = 1'b0; // see R5
				state_d           = ST_WR_END;
			end
			ST_WR_END: begin
				// control-terminated write; data held through the edge
				pins_d.writeReadN = 1'b1; // see R4
				rspData_d         = cmd_q.data;
				rspValid_d        = 1'b1;
				wait_d            = RECOVER_WAIT;
				state_d           = ST_RECOVER;
			end
			ST_RECOVER: begin
				pins_d      = PINS_IDLE;
				pins_d.addr = pins_q.addr;
				// flag select stays off long enough before the next access
				if (wait_q != 4'h0) begin
					wait_d = wait_q - 4'h1;
				end else begin
					ready_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				pins_d  = PINS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= ST_IDLE;
			cmd_q        <= '0;
			pins_q       <= PINS_IDLE;
			wait_q       <= 4'h0;
			ready_q      <= 1'b0;
			rspValid_q   <= 1'b0;
			rspData_q    <= DATA_ZERO;
			intPending_q <= 1'b0;
			holdSeen_q   <= 1'b0;
		end else begin
			state_q      <= state_d;
			cmd_q        <= cmd_d;
			pins_q       <= pins_d;
			wait_q       <= wait_d;
			ready_q      <= ready_d;
			rspValid_q   <= rspValid_d;
			rspData_q    <= rspData_d;
			intPending_q <= intActive; // see R11
			holdSeen_q   <= holdActive; // see R16
		end
	end

	assign cmdReady   = ready_q;
	assign rspValid   = rspValid_q;
	assign rspData    = rspData_q;
	assign intPending = intPending_q;
	assign holdSeen   = holdSeen_q;
	assign pinsOut    = pins_q;

endmodule // dpr_port_host
`default_nettype wire

// [tb/dpr_port_host_assertions.sv]
// pin-order assertions on the port controller
`timescale 1ns/10ps
`default_nettype none
module dpr_port_host_assertions
	import dpr_host_pkg::*;
(
	input wire logic                sys_clk,
	input wire logic                rst_n,
	input wire logic                cmdValid,
	input wire dpr_host_pkg::cmd_t  cmd,
	input wire logic                cmdReady,
	input wire logic                rspValid,
	input wire logic                holdSeen,
	input wire dpr_host_pkg::pins_t pinsOut
);
	// ------
	// checks
	// ------
	logic sel;
	assign sel = (!pinsOut.portSelectLowTrue && pinsOut.portSelectHighTrue)
		|| !pinsOut.flagLatchSelectN;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wrGo; $fell(pinsOut.writeReadN); endsequence
	sequence s_wrDone; pinsOut.writeReadN && rspValid; endsequence
	property p_rdHigh; !pinsOut.outputEnableN |-> pinsOut.writeReadN; endproperty
	a_rdHigh: assert property (p_rdHigh) else $error("enable during write");
	property p_addr;
		!$stable(pinsOut.addr) |-> pinsOut.writeReadN && $past(pinsOut.writeReadN);
	endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	property p_wrSel; s_wrGo |-> sel && pinsOut.dataOe; endproperty
	a_wrSel: assert property (p_wrSel) else $error("write without select");
	property p_selFirst; s_wrGo |-> $past(sel); endproperty
	a_selFirst: assert property (p_selFirst) else $error("select not first");
	property p_wrEnd; s_wrGo |-> ##[1:3] s_wrDone; endproperty
	a_wrEnd: assert property (p_wrEnd) else $error("write not ended");
	property p_dataHeld; !pinsOut.writeReadN |-> pinsOut.dataOe && $stable(pinsOut.dataOut);
	endproperty
	a_dataHeld: assert property (p_dataHeld) else $error("data moved in write");
	property p_fresh;
		$fell(pinsOut.outputEnableN) && !pinsOut.flagLatchSelectN
			|-> $fell(pinsOut.flagLatchSelectN);
	endproperty
	a_fresh: assert property (p_fresh) else $error("stale flag select");
	property p_hold; s_wrGo |-> !$past(holdSeen); endproperty
	a_hold: assert property (p_hold) else $error("write while held");
	property p_rdWait;
		cmdValid && cmdReady && !cmd.op[0] |=> !rspValid[*6] ##[1:10] rspValid;
	endproperty
	a_rdWait: assert property (p_rdWait) else $error("read answer timing");
endmodule // dpr_port_host_assertions
bind dpr_port_host dpr_port_host_assertions chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .rspValid(rspValid),
	.holdSeen(holdSeen), .pinsOut(pinsOut));
`default_nettype wire

// [tb/dpr_device_model.sv]
// behavioural memory device seen from the host port
`timescale 1ns/10ps
`default_nettype none
module dpr_device_model
	import dpr_host_pkg::*;
(
	input  wire dpr_host_pkg::pins_t              pinsOut,
	input  wire logic                             holdReq,
	input  wire logic                             otherPost,
	output var  logic [dpr_host_pkg::DATA_W-1:0]  dataIn,
	output var  logic                             holdN,
	output var  logic                             mailIntN
);
	// ------
	// storage
	// ------
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] word;
	logic [7:0]        flagOwn;
	logic              memSel;
	logic              flagSel;
	logic              rightIntN;
	logic              ownRead;
	logic              wrOn;
	logic              wrFlag;
	pins_t             wrPins;
	assign memSel = !pinsOut.portSelectLowTrue && pinsOut.portSelectHighTrue;
	assign flagSel = !pinsOut.flagLatchSelectN;
	assign holdN = !holdReq; // bench commands the arbitration outcome
	initial begin
		foreach (mem[i]) mem[i] = '0;
		flagOwn = '0;
		mailIntN = 1'b1;
		rightIntN = 1'b1;
		wrOn = 1'b0;
	end
	// write is latched during the overlap, so a select-ended write keeps its kind and data
	always @(pinsOut) begin
		if (!pinsOut.writeReadN && (!pinsOut.flagLatchSelectN
			|| (!pinsOut.portSelectLowTrue && pinsOut.portSelectHighTrue))) begin
			wrPins = pinsOut;
			wrFlag = !pinsOut.flagLatchSelectN;
			wrOn   = 1'b1;
		end else if (wrOn) begin
			wrOn = 1'b0;
			if (wrFlag) flagOwn[wrPins.addr[2:0]] = !wrPins.dataOut[0];
			else if (holdN) begin
				for (int i = 0; i < LANE_W; i++)
					if (!wrPins.byteLaneSelectN[i])
						mem[wrPins.addr[7:0]][9*i +: 9] = wrPins.dataOut[9*i +: 9];
				if (wrPins.addr == MBOX_RIGHT) rightIntN = 1'b0;
			end
		end
	end
	// released lanes show the inverse, so a floating bus never looks right
	always_comb begin
		word = flagSel ? {35'h0, !flagOwn[pinsOut.addr[2:0]]} : mem[pinsOut.addr[7:0]];
		for (int i = 0; i < LANE_W; i++)
			dataIn[9*i +: 9] = ((memSel && !pinsOut.byteLaneSelectN[i]) || flagSel)
				&& !pinsOut.outputEnableN && pinsOut.writeReadN
				? word[9*i +: 9] : ~word[9*i +: 9];
	end
	assign ownRead = memSel && !pinsOut.outputEnableN && pinsOut.writeReadN && holdN
		&& pinsOut.addr == MBOX_LEFT;
	// a post from the far port wins over a clear in the same instant
	always @(posedge otherPost or posedge ownRead) mailIntN = !otherPost;
endmodule // dpr_device_model
`default_nettype wire

// [tb/test_dpr_port_host.sv]
// self-checking bench for the port controller
`timescale 1ns/10ps
`default_nettype none
module test_dpr_port_host;
	import dpr_host_pkg::*;
	// ------
	// wiring
	// ------
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              cmdValid = 1'b0;
	cmd_t              cmd = '0;
	logic              cmdReady, rspValid, intPending, holdSeen, holdN, mailIntN;
	logic [DATA_W-1:0] rspData, dataIn, q;
	pins_t             pinsOut;
	logic              holdReq = 1'b0;
	logic              otherPost = 1'b0;
	int                error_cnt = 0;
	int                n_tests = 0;
	always #50 sys_clk = ~sys_clk;
	dpr_port_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .intPending(intPending),
		.holdSeen(holdSeen), .pinsOut(pinsOut), .dataIn(dataIn), .holdN(holdN),
		.mailIntN(mailIntN));
	dpr_device_model dev (.pinsOut(pinsOut), .holdReq(holdReq), .otherPost(otherPost),
		.dataIn(dataIn), .holdN(holdN), .mailIntN(mailIntN));
	task automatic check(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic do_cmd(input op_t op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [LANE_W-1:0] ln);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd = '{op, a, d, ln};
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && n < 50) begin @(negedge sys_clk); n++; end
		@(negedge sys_clk);
		cmdValid = 1'b0;
		while (rspValid !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
		check("response", 1'b1, n < 300);
		q = rspData;
	endtask
	task automatic t_mem;
		do_cmd(OP_MEM_WRITE, 15'h0123, 36'h123456789, 4'h0);
		check("echo", 36'h123456789, q);
		do_cmd(OP_MEM_WRITE, 15'h0123, 36'hfffffffff, 4'he);
		do_cmd(OP_MEM_READ, 15'h0123, 36'h0, 4'h0);
		check("word", 36'h1234567ff, q);
		do_cmd(OP_MEM_READ, 15'h0123, 36'h0, 4'h7);
		check("top lane", 9'h024, q[35:27]);
		$display("t_mem done");
	endtask
	task automatic t_flag;
		do_cmd(OP_FLAG_READ, 15'h0005, 36'h0, 4'h0);
		check("flag free", 36'h1, q);
		do_cmd(OP_FLAG_WRITE, 15'h7ff5, 36'h0, 4'h0);
		do_cmd(OP_FLAG_READ, 15'h0005, 36'h0, 4'h0);
		check("flag taken", 36'h0, q);
		do_cmd(OP_FLAG_READ, 15'h0004, 36'h0, 4'h0);
		check("flag other", 36'h1, q);
		do_cmd(OP_FLAG_WRITE, 15'h0005, 36'h1, 4'h0);
		do_cmd(OP_FLAG_READ, 15'h0005, 36'h0, 4'h0);
		check("flag freed", 36'h1, q);
		$display("t_flag done");
	endtask
	task automatic t_mail;
		otherPost = 1'b1;
		repeat (6) @(negedge sys_clk);
		otherPost = 1'b0;
		check("int set", 1'b1, intPending);
		do_cmd(OP_MEM_READ, MBOX_RIGHT, 36'h0, 4'h0);
		repeat (6) @(negedge sys_clk);
		check("int kept", 1'b1, intPending);
		do_cmd(OP_MEM_READ, MBOX_LEFT, 36'h0, 4'h0);
		repeat (6) @(negedge sys_clk);
		check("int cleared", 1'b0, intPending);
		do_cmd(OP_MEM_WRITE, MBOX_RIGHT, 36'h5, 4'h0);
		check("far int", 1'b0, dev.rightIntN);
		$display("t_mail done");
	endtask
	task automatic t_hold;
		int lows;
		lows = 0;
		holdReq = 1'b1;
		otherPost = 1'b1;
		repeat (6) @(negedge sys_clk);
		otherPost = 1'b0;
		check("hold seen", 1'b1, holdSeen);
		do_cmd(OP_MEM_READ, MBOX_LEFT, 36'h0, 4'h0);
		repeat (6) @(negedge sys_clk);
		check("int held", 1'b1, intPending);
		fork
			do_cmd(OP_MEM_WRITE, 15'h0042, 36'h0aaaa5555, 4'h0);
		join_none
		repeat (30) begin @(negedge sys_clk); if (!pinsOut.writeReadN) lows++; end
		check("held write", 0, lows);
		holdReq = 1'b0;
		wait fork;
		do_cmd(OP_MEM_READ, 15'h0042, 36'h0, 4'h0);
		check("late write", 36'h0aaaa5555, q);
		$display("t_hold done");
	endtask
	task automatic t_reset;
		rst_n = 1'b0;
		@(negedge sys_clk);
		check("reset pins", 1'b1, pinsOut === PINS_IDLE);
		check("reset int", 1'b0, intPending);
		check("reset ready", 1'b0, cmdReady);
		rst_n = 1'b1;
		@(negedge sys_clk);
		check("ready after reset", 1'b1, cmdReady);
		repeat (6) @(negedge sys_clk);
		check("int after reset", 1'b1, intPending);
		do_cmd(OP_MEM_READ, 15'h0042, 36'h0, 4'h0);
		check("kept word", 36'h0aaaa5555, q);
		$display("t_reset done");
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_mem();
		t_flag();
		t_mail();
		t_hold();
		t_reset();
		finish_test();
	end
	// whole run is under a thousand cycles, so this leaves wide margin
	initial begin
		#(100 * 5000);
		error_cnt++;
		finish_test();
	end
endmodule // test_dpr_port_host
`default_nettype wire
